// ==== dv/tcc_capture_compare_asserts.sv ====
// Checker: bus handshakes and the causes of requests and output changes.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module tcc_capture_compare_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Events and results
  input wire logic        timer_tick,
  input wire logic        capture_input_pin,
  input wire logic        comparator_result,
  input wire logic [2:0]  irq_ack,
  input wire logic        capture_irq,
  input wire logic [1:0]  compare_irq,
  input wire logic [1:0]  compare_output
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       wr_go;     // Write taken this edge
  logic [1:0] src_ff;    // Source levels one cycle ago
  logic [3:0] quiet_ff;  // Cycles since a source change or write
  logic [3:0] nxt_quiet; // Next quiet count
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // Saturating count, restarted by any possible capture cause
  always_comb begin
    nxt_quiet = (quiet_ff == 4'hF) ? quiet_ff : quiet_ff + 4'h1;
    if (wr_go || (src_ff != {capture_input_pin, comparator_result})) begin
      nxt_quiet = 4'h0;
    end
  end
  // Register the helper state
  always_ff @(posedge clk) begin
    src_ff   <= {capture_input_pin, comparator_result};
    quiet_ff <= rst_n ? nxt_quiet : 4'h0;
  end
  property p_wr_acc; (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
    && (s_axi_wready == s_axi_awready); endproperty
  a_wr_acc: assert property (p_wr_acc) else $error("write accept wrong");
  property p_wr_ans; wr_go |=> s_axi_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer wrong");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  property p_err0; s_axi_rvalid && (s_axi_rresp == tcc_pkg::RESP_SLVERR) |->
    s_axi_rdata == 32'h0000_0000; endproperty
  a_err0: assert property (p_err0) else $error("error read not zero");
  property p_out; $changed(compare_output) |-> $past(timer_tick) || $past(wr_go)
    || $past(wr_go, 2); endproperty
  a_out: assert property (p_out) else $error("output moved uncaused");
  property p_cmp_irq; (compare_irq & ~$past(compare_irq)) != 2'b00 |->
    $past(timer_tick) || $past(wr_go); endproperty
  a_cmp_irq: assert property (p_cmp_irq) else $error("compare request uncaused");
  property p_ack; irq_ack[1] && !timer_tick |=> !compare_irq[0]; endproperty
  a_ack: assert property (p_ack) else $error("serviced request stays");
  property p_cap; $rose(capture_irq) |-> quiet_ff <= 4'd10; endproperty
  a_cap: assert property (p_cap) else $error("capture request late");
  c_cap: cover property ($rose(capture_irq));
  c_cmp: cover property ($rose(compare_irq[0]));
  c_out: cover property ($changed(compare_output));
  c_err: cover property (s_axi_rvalid && (s_axi_rresp == tcc_pkg::RESP_SLVERR));
endmodule // tcc_capture_compare_asserts
bind tcc_capture_compare tcc_capture_compare_asserts i_chk (.clk, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .timer_tick, .capture_input_pin, .comparator_result, .irq_ack, .capture_irq,
  .compare_irq, .compare_output);
`default_nettype wire

// ==== dv/tcc_capture_compare_tb_top.sv ====
// Testbench: bus tasks and directed capture and compare sequences.
// Assumes the event model drives ticks and both trigger sources.
`timescale 1ns/10ps
`default_nettype none
module tcc_capture_compare_tb_top;
  // Driven inputs
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  s_axi_awaddr = 6'h00;
  logic [5:0]  s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [2:0]  irq_ack = 3'h0;
  // Outputs, event lines and results
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, compare_irq, compare_output, rd_resp;
  logic [31:0] s_axi_rdata, rd_data;
  logic        timer_tick, capture_input_pin, comparator_result, capture_irq, o_keep;
  int          err_total = 0;
  int          total_checks = 0;
  tcc_capture_compare i_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_tick, .capture_input_pin,
    .comparator_result, .irq_ack, .capture_irq, .compare_irq, .compare_output);
  tcc_evt_model i_evt (.clk, .timer_tick, .capture_input_pin, .comparator_result);
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Write one byte register, address and data together
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do @(posedge clk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready  <= 1'b0;
  endtask
  // Read one register into rd_data and rd_resp
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready  <= 1'b0;
  endtask
  // 16-bit write, high byte first
  task automatic wr16(input logic [5:0] a, input logic [15:0] v);
    wr(a + 6'h04, v[15:8]);
    wr(a, v[7:0]);
  endtask
  // 16-bit read, low byte first, then compare
  task automatic rd16(input logic [5:0] a, input logic [15:0] exp);
    logic [7:0] lo;
    rd(a);
    lo = rd_data[7:0];
    rd(a + 6'h04);
    chk({rd_data[7:0], lo}, exp);
  endtask
  // Read the flag register and check one bit
  task automatic flg(input int b, input logic e);
    rd(tcc_pkg::OFS_FLAGS);
    chk(16'(rd_data[b]), 16'(e));
  endtask
  // Set control, clear the flag, move one source, then check the capture
  task automatic cap(input logic [7:0] ctl, input logic comp, input logic lvl,
                     input logic [15:0] cnt, input logic hit);
    wr(tcc_pkg::OFS_CTRL, ctl);
    wr16(tcc_pkg::OFS_CNT_L, cnt);
    wr(tcc_pkg::OFS_FLAGS, 8'h01); // Clear after a source or edge change
    i_evt.set_src(comp, lvl);
    repeat (3) @(posedge clk);
    flg(tcc_pkg::FLG_CAP, hit & !ctl[5]); // Filter delays by four cycles
    repeat (8) @(posedge clk);
    flg(tcc_pkg::FLG_CAP, hit);
    chk(16'(capture_irq), 16'(hit));
    if (hit) begin
      rd16(tcc_pkg::OFS_CAP_L, cnt);
    end
  endtask
  // Counts, verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(tcc_pkg::OFS_CMODE);
    chk(16'(rd_data[7:0]), 16'(tcc_pkg::CMODE_RST)); // Requests off
    rd(6'h30);
    chk({rd_data[13:0], rd_resp}, 16'(tcc_pkg::RESP_SLVERR));
    wr(tcc_pkg::OFS_CMODE, 8'h61);
    $display("test bus done");
    cap(8'h40, 1'b0, 1'b1, 16'h1234, 1'b1);
    cap(8'h40, 1'b0, 1'b0, 16'h2345, 1'b0);
    cap(8'h00, 1'b0, 1'b1, 16'h3456, 1'b0);
    cap(8'h00, 1'b0, 1'b0, 16'h4567, 1'b1);
    cap(8'hC0, 1'b1, 1'b1, 16'h5678, 1'b1);
    cap(8'hC0, 1'b0, 1'b1, 16'h6789, 1'b0);
    cap(8'h60, 1'b0, 1'b0, 16'h789A, 1'b0);
    cap(8'h60, 1'b0, 1'b1, 16'h89AB, 1'b1);
    @(posedge clk);
    irq_ack <= 3'h1;
    @(posedge clk);
    irq_ack <= 3'h0;
    i_evt.set_src(1'b0, 1'b0);
    i_evt.set_src(1'b0, 1'b1);
    repeat (10) @(posedge clk);
    flg(tcc_pkg::FLG_CAP, 1'b0); // Ack cleared, short pulse rejected
    cap(8'h0C, 1'b0, 1'b0, 16'h1111, 1'b0);
    wr16(tcc_pkg::OFS_CAP_L, 16'hBEEF);
    rd16(tcc_pkg::OFS_CAP_L, 16'hBEEF);
    wr(tcc_pkg::OFS_CTRL, 8'h40);
    wr16(tcc_pkg::OFS_CAP_L, 16'h0F0F);
    rd16(tcc_pkg::OFS_CAP_L, 16'hBEEF);
    wr(tcc_pkg::OFS_CNT_H, 8'hAB);
    wr(tcc_pkg::OFS_CMA_L, 8'hCD);
    rd16(tcc_pkg::OFS_CMA_L, 16'hABCD);
    $display("test capture done");
    wr16(tcc_pkg::OFS_CMA_L, 16'h0005);
    wr16(tcc_pkg::OFS_CNT_L, 16'h0000);
    wr(tcc_pkg::OFS_FLAGS, 8'h07);
    i_evt.ticks(5, 0);
    flg(tcc_pkg::FLG_CMA, 1'b0);
    i_evt.ticks(1, 3);
    flg(tcc_pkg::FLG_CMA, 1'b1);
    chk({12'h000, compare_irq, compare_output}, 16'h0005);
    @(posedge clk);
    irq_ack <= 3'h2;
    @(posedge clk);
    irq_ack <= 3'h0;
    @(posedge clk);
    chk(16'(compare_irq[0]), 16'h0000);
    wr16(tcc_pkg::OFS_CNT_L, 16'h0005);
    i_evt.ticks(1, 2);
    flg(tcc_pkg::FLG_CMA, 1'b0);
    wr(tcc_pkg::OFS_FORCE, 8'h01);
    repeat (2) @(posedge clk);
    chk(16'(compare_output[0]), 16'h0000); // Toggled back
    flg(tcc_pkg::FLG_CMA, 1'b0);
    rd16(tcc_pkg::OFS_CNT_L, 16'h0006);
    wr(tcc_pkg::OFS_CTRL, 8'h44);
    wr16(tcc_pkg::OFS_CMA_L, 16'h0003);
    wr16(tcc_pkg::OFS_CNT_L, 16'h0000);
    i_evt.ticks(5, 1);
    rd16(tcc_pkg::OFS_CNT_L, 16'h0001);
    wr(tcc_pkg::OFS_CTRL, 8'h45);
    wr16(tcc_pkg::OFS_CNT_L, 16'h0009);
    wr16(tcc_pkg::OFS_CMA_L, 16'h000B);
    rd16(tcc_pkg::OFS_CMA_L, 16'h000B);
    wr(tcc_pkg::OFS_FLAGS, 8'h07);
    i_evt.ticks(252, 0);
    flg(tcc_pkg::FLG_CMA, 1'b0); // No match on counts 9 up to top and 0 to 4
    i_evt.ticks(7, 0);
    flg(tcc_pkg::FLG_CMA, 1'b1);
    o_keep = compare_output[0];
    wr(tcc_pkg::OFS_FORCE, 8'h01);
    repeat (2) @(posedge clk);
    chk(16'(compare_output[0]), 16'(o_keep)); // No force in PWM
    $display("test compare done");
    results();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results();
  end
endmodule // tcc_capture_compare_tb_top
`default_nettype wire

// ==== dv/tcc_evt_model.sv ====
// Event source model: prescaled timer ticks and the two trigger levels.
// Assumes the testbench calls its tasks by hierarchical name.
`timescale 1ns/10ps
`default_nettype none
module tcc_evt_model (
  // Clock
  input  wire logic clk,
  // Lines toward the timer
  output logic      timer_tick,
  output logic      capture_input_pin,
  output logic      comparator_result
);
  // Quiet lines at start
  initial begin
    timer_tick        = 1'b0;
    capture_input_pin = 1'b0;
    comparator_result = 1'b0;
  end
  // Move one trigger source just after an edge
  task automatic set_src(input logic comp, input logic lvl);
    @(posedge clk);
    if (comp) begin
      comparator_result <= lvl;
    end else begin
      capture_input_pin <= lvl; // Port-driven pin level
    end
  endtask
  // One-cycle ticks, gap plus one idle cycles apart, for prompt or slow counting
  task automatic ticks(input int n, input int gap);
    repeat (n) begin
      @(posedge clk);
      timer_tick <= 1'b1;
      @(posedge clk);
      timer_tick <= 1'b0;
      repeat (gap) @(posedge clk);
    end
  endtask
endmodule // tcc_evt_model
`default_nettype wire

// ==== verilog/tcc_capture_compare.sv ====
// 16-bit timer with input capture and two output compare units, AXI4-Lite slave.
// Assumes pin inputs and the prescaled count tick are synchronous to clk.
// Functional notes
// - Qualified edge copies counter into capture register
// - Capture flag set with the same copy
// - Capture flag interrupts; cleared by ack or one
// - Counter or capture low read latches high byte into holding
// - Capture writable only in capture-top modes
// - Comparator select bit picks trigger source
// - Filter output changes after four equal samples
// - Filter adds four system clocks, ignores prescaler
// - Capture disabled in capture-top modes only
// - Port-driven pin level still triggers capture
// - Every capture overwrites the capture register
// - Match sets compare flag on timer tick
// - Compare flags interrupt; cleared by ack or one
// - Compare A gives top in selected modes
// - PWM modes double buffer, load at top
// - CPU reaches buffer or active; direct reads
// - High write to holding; low commits both
// - Force strobe acts as match in non-PWM modes, no flag
// - One holding register for all 16-bit registers
// - Counter write blocks next tick's matches
`timescale 1ns/10ps
`default_nettype none
module tcc_capture_compare (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AXI4-Lite write address and data
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Timer tick and event inputs
  input  wire logic        timer_tick,
  input  wire logic        capture_input_pin,
  input  wire logic        comparator_result,
  // Interrupt requests and service acks
  input  wire logic [2:0]  irq_ack,
  output logic             capture_irq,
  output logic [1:0]       compare_irq,
  // Waveform outputs
  output logic [1:0]       compare_output
);

  // Register state
  tcc_pkg::tcc_ctrl_t  ctrl_ff, nxt_ctrl;     // Mode and capture control
  tcc_pkg::tcc_cmode_t cmode_ff, nxt_cmode;   // Output modes, enables
  logic [2:0]  flags_ff, nxt_flags;           // Sticky event flags
  logic [7:0]  temp_ff, nxt_temp;             // Shared high-byte holding
  logic [15:0] cnt_ff, nxt_cnt;               // Counter value
  logic [15:0] cap_ff, nxt_cap;               // Capture register
  logic [15:0] cma_ff, nxt_cma;               // Active compare A
  logic [15:0] cmb_ff, nxt_cmb;               // Active compare B
  logic [15:0] bfa_ff, nxt_bfa;               // Compare A buffer
  logic [15:0] bfb_ff, nxt_bfb;               // Compare B buffer
  logic        blk_ff, nxt_blk;               // Match block after counter write
  logic [1:0]  oc_ff, nxt_oc;                 // Compare output levels
  // Capture path state
  logic [3:0]  samp_ff, nxt_samp;             // Filter sample history
  logic        filt_ff, nxt_filt;             // Filtered level
  logic        prev_ff, nxt_prev;             // Previous edge-detector level
  // Bus state
  logic        bvalid_ff, nxt_bvalid;
  logic [1:0]  bresp_ff, nxt_bresp;
  logic        rvalid_ff, nxt_rvalid;
  logic [1:0]  rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;

  // Decoded mode properties, handshakes, capture and compare signals
  logic        pwm_mode;                      // Any of the twelve PWM modes
  logic        cap_top;                       // Capture register gives top
  logic        cma_top;                       // Compare A gives top
  logic [15:0] top_val;                       // Current counting limit
  logic        at_top;                        // Counter at its limit
  logic        wr_go;                         // Write taken this cycle
  logic        rd_go;                         // Read taken this cycle
  logic        src;                           // Selected trigger level
  logic        det_in;                        // Level into edge detector
  logic        cap_evt;                       // Qualified capture edge
  logic [1:0]  hit;                           // Real matches this tick
  logic [1:0]  act;                           // Output action requests
  logic [1:0]  force_wr;                      // Force strobes written

  // Mode decode
  always_comb begin
    unique case (ctrl_ff.waveform_mode_sel)
      4'd0, 4'd4, 4'd12, 4'd13: pwm_mode = 1'b0;
      default:                  pwm_mode = 1'b1;
    endcase
    cap_top = (ctrl_ff.waveform_mode_sel == 4'd8) || (ctrl_ff.waveform_mode_sel == 4'd10) ||
              (ctrl_ff.waveform_mode_sel == 4'd12) || (ctrl_ff.waveform_mode_sel == 4'd14);
    cma_top = (ctrl_ff.waveform_mode_sel == 4'd4) || (ctrl_ff.waveform_mode_sel == 4'd9) ||
              (ctrl_ff.waveform_mode_sel == 4'd11) || (ctrl_ff.waveform_mode_sel == 4'd15);
    // Counting limit selection
    if (cma_top) begin
      top_val = cma_ff;
    end else if (cap_top) begin
      top_val = cap_ff;
    end else begin
      unique case (ctrl_ff.waveform_mode_sel)
        4'd1, 4'd5: top_val = tcc_pkg::TOP_8BIT;
        4'd2, 4'd6: top_val = tcc_pkg::TOP_9BIT;
        4'd3, 4'd7: top_val = tcc_pkg::TOP_10BIT;
        default:    top_val = tcc_pkg::TOP_MAX;
      endcase
    end
    at_top = (cnt_ff == top_val);
  end

  // Bus handshakes: write needs address and data together
  always_comb begin
    wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
    rd_go         = s_axi_arvalid && !rvalid_ff;
    s_axi_awready = wr_go;
    s_axi_wready  = wr_go;
    s_axi_arready = !rvalid_ff;
    force_wr      = (wr_go && s_axi_wstrb[0] && s_axi_awaddr == tcc_pkg::OFS_FORCE) ?
                    s_axi_wdata[1:0] : 2'b00;
  end

  // Capture path: source select, filter, edge detector
  always_comb begin
    // Pin is sampled even when its port drives it
    src    = ctrl_ff.comparator_capture_select ? comparator_result
                                               : capture_input_pin;
    nxt_samp = {samp_ff[2:0], src};
    nxt_filt = filt_ff;
    if (samp_ff == 4'hF) begin
      nxt_filt = 1'b1;
    end else if (samp_ff == 4'h0) begin
      nxt_filt = 1'b0;
    end
    // Filtered path adds the four-sample delay on clk
    det_in   = ctrl_ff.capture_filter_enable ? filt_ff : samp_ff[0];
    nxt_prev = det_in;
    // Edge polarity choice
    cap_evt  = (ctrl_ff.capture_edge_select ? (det_in && !prev_ff) : (!det_in && prev_ff))
               && !cap_top;
  end

  // Compare match detection on the timer tick
  always_comb begin
    hit[0] = timer_tick && !blk_ff && (cnt_ff == cma_ff);
    hit[1] = timer_tick && !blk_ff && (cnt_ff == cmb_ff);
    // Force strobe acts like a match in non-PWM modes
    act    = hit | (pwm_mode ? 2'b00 : force_wr);
  end

  // Next state of timer, registers and bus
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_cmode  = cmode_ff;
    nxt_flags  = flags_ff;
    nxt_temp   = temp_ff;
    nxt_cnt    = cnt_ff;
    nxt_cap    = cap_ff;
    nxt_cma    = cma_ff;
    nxt_cmb    = cmb_ff;
    nxt_bfa    = bfa_ff;
    nxt_bfb    = bfb_ff;
    nxt_blk    = blk_ff;
    nxt_oc     = oc_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp  = rresp_ff;
    nxt_rdata  = rdata_ff;

    // Counter: block lasts until next tick
    if (timer_tick) begin
      nxt_blk = 1'b0;
      if (at_top && (cma_top || cap_top || pwm_mode)) begin
        nxt_cnt = 16'h0000;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
      // Buffered compare values load at the limit
      if (pwm_mode && at_top) begin
        nxt_cma = bfa_ff;
        nxt_cmb = bfb_ff;
      end
    end

    // Output levels per compare output mode
    for (int i = 0; i < 2; i++) begin
      if (act[i]) begin
        unique case (i == 0 ? cmode_ff.compare_output_mode_a : cmode_ff.compare_output_mode_b)
          2'b01:   nxt_oc[i] = !oc_ff[i];
          2'b10:   nxt_oc[i] = 1'b0;
          2'b11:   nxt_oc[i] = 1'b1;
          default: nxt_oc[i] = oc_ff[i];
        endcase
      end
    end

    // Capture: each event overwrites
    if (cap_evt) begin
      nxt_cap = cnt_ff;
    end

    // Flag clears by service ack
    nxt_flags = nxt_flags & ~irq_ack;

    // Register write
    if (wr_go) begin
      nxt_bvalid = 1'b1;
      nxt_bresp  = tcc_pkg::RESP_OKAY;
      if (s_axi_wstrb[0]) begin
        unique case (s_axi_awaddr)
          tcc_pkg::OFS_CTRL:  nxt_ctrl  = s_axi_wdata[7:0];
          tcc_pkg::OFS_CMODE: nxt_cmode = s_axi_wdata[7:0];
          tcc_pkg::OFS_FLAGS: nxt_flags = nxt_flags & ~s_axi_wdata[2:0];
          tcc_pkg::OFS_FORCE: nxt_blk   = blk_ff;
          tcc_pkg::OFS_CNT_H, tcc_pkg::OFS_CAP_H,
          tcc_pkg::OFS_CMA_H, tcc_pkg::OFS_CMB_H: begin
            nxt_temp = s_axi_wdata[7:0];
          end
          tcc_pkg::OFS_CNT_L: begin
            nxt_cnt = {temp_ff, s_axi_wdata[7:0]};
            nxt_blk = 1'b1;
          end
          tcc_pkg::OFS_CAP_L: begin
            if (cap_top) begin
              nxt_cap = {temp_ff, s_axi_wdata[7:0]};
            end
          end
          tcc_pkg::OFS_CMA_L: begin
            if (pwm_mode) begin
              nxt_bfa = {temp_ff, s_axi_wdata[7:0]};
            end else begin
              nxt_cma = {temp_ff, s_axi_wdata[7:0]};
            end
          end
          tcc_pkg::OFS_CMB_L: begin
            if (pwm_mode) begin
              nxt_bfb = {temp_ff, s_axi_wdata[7:0]};
            end else begin
              nxt_cmb = {temp_ff, s_axi_wdata[7:0]};
            end
          end
          default: nxt_bresp = tcc_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_awaddr > tcc_pkg::OFS_CMB_H || s_axi_awaddr[1:0] != 2'b00) begin
        nxt_bresp = tcc_pkg::RESP_SLVERR;
      end
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end

    // Hardware sets win over clears
    if (cap_evt) begin
      nxt_flags[tcc_pkg::FLG_CAP] = 1'b1;
    end
    if (hit[0]) begin
      nxt_flags[tcc_pkg::FLG_CMA] = 1'b1;
    end
    if (hit[1]) begin
      nxt_flags[tcc_pkg::FLG_CMB] = 1'b1;
    end

    // Register read
    if (rd_go) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = tcc_pkg::RESP_OKAY;
      nxt_rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        tcc_pkg::OFS_CTRL:  nxt_rdata[7:0] = ctrl_ff;
        tcc_pkg::OFS_CMODE: nxt_rdata[7:0] = cmode_ff;
        tcc_pkg::OFS_FLAGS: nxt_rdata[2:0] = flags_ff;
        tcc_pkg::OFS_FORCE: nxt_rdata[7:0] = 8'h00;
        tcc_pkg::OFS_CNT_L: begin
          nxt_rdata[7:0] = cnt_ff[7:0];
          nxt_temp       = cnt_ff[15:8];
        end
        tcc_pkg::OFS_CAP_L: begin
          nxt_rdata[7:0] = cap_ff[7:0];
          nxt_temp       = cap_ff[15:8];
        end
        tcc_pkg::OFS_CNT_H, tcc_pkg::OFS_CAP_H: nxt_rdata[7:0] = temp_ff;
        tcc_pkg::OFS_CMA_L: nxt_rdata[7:0] = pwm_mode ? bfa_ff[7:0] : cma_ff[7:0];
        tcc_pkg::OFS_CMA_H: nxt_rdata[7:0] = pwm_mode ? bfa_ff[15:8] : cma_ff[15:8];
        tcc_pkg::OFS_CMB_L: nxt_rdata[7:0] = pwm_mode ? bfb_ff[7:0] : cmb_ff[7:0];
        tcc_pkg::OFS_CMB_H: nxt_rdata[7:0] = pwm_mode ? bfb_ff[15:8] : cmb_ff[15:8];
        default: nxt_rresp = tcc_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff   <= tcc_pkg::CTRL_RST;
      cmode_ff  <= tcc_pkg::CMODE_RST;
      flags_ff  <= 3'b000;
      temp_ff   <= 8'h00;
      cnt_ff    <= 16'h0000;
      cap_ff    <= 16'h0000;
      cma_ff    <= 16'h0000;
      cmb_ff    <= 16'h0000;
      bfa_ff    <= 16'h0000;
      bfb_ff    <= 16'h0000;
      blk_ff    <= 1'b0;
      oc_ff     <= 2'b00;
      samp_ff   <= 4'h0;
      filt_ff   <= 1'b0;
      prev_ff   <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= 2'b00;
      rvalid_ff <= 1'b0;
      rresp_ff  <= 2'b00;
      rdata_ff  <= 32'h0000_0000;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      cmode_ff  <= nxt_cmode;
      flags_ff  <= nxt_flags;
      temp_ff   <= nxt_temp;
      cnt_ff    <= nxt_cnt;
      cap_ff    <= nxt_cap;
      cma_ff    <= nxt_cma;
      cmb_ff    <= nxt_cmb;
      bfa_ff    <= nxt_bfa;
      bfb_ff    <= nxt_bfb;
      blk_ff    <= nxt_blk;
      oc_ff     <= nxt_oc;
      samp_ff   <= nxt_samp;
      filt_ff   <= nxt_filt;
      prev_ff   <= nxt_prev;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff  <= nxt_rresp;
      rdata_ff  <= nxt_rdata;
    end
  end

  // Outputs
  always_comb begin
    s_axi_bvalid   = bvalid_ff;
    s_axi_bresp    = bresp_ff;
    s_axi_rvalid   = rvalid_ff;
    s_axi_rresp    = rresp_ff;
    s_axi_rdata    = rdata_ff;
    compare_output = oc_ff;
    capture_irq    = flags_ff[tcc_pkg::FLG_CAP] && cmode_ff.capture_irq_enable;
    compare_irq[0] = flags_ff[tcc_pkg::FLG_CMA] && cmode_ff.compare_irq_enable_a;
    compare_irq[1] = flags_ff[tcc_pkg::FLG_CMB] && cmode_ff.compare_irq_enable_b;
  end

endmodule // tcc_capture_compare
`default_nettype wire

// ==== verilog/tcc_pkg.sv ====
// Package for the timer capture/compare block: register map, fields, reset values.
// Assumes a 32-bit AXI4-Lite register bus with one byte register per aligned word.
package tcc_pkg;
  // Register byte offsets
  localparam logic [5:0] OFS_CTRL  = 6'h00;
  localparam logic [5:0] OFS_CMODE = 6'h04;
  localparam logic [5:0] OFS_FLAGS = 6'h08;
  localparam logic [5:0] OFS_FORCE = 6'h0C;
  localparam logic [5:0] OFS_CNT_L = 6'h10;
  localparam logic [5:0] OFS_CNT_H = 6'h14;
  localparam logic [5:0] OFS_CAP_L = 6'h18;
  localparam logic [5:0] OFS_CAP_H = 6'h1C;
  localparam logic [5:0] OFS_CMA_L = 6'h20;
  localparam logic [5:0] OFS_CMA_H = 6'h24;
  localparam logic [5:0] OFS_CMB_L = 6'h28;
  localparam logic [5:0] OFS_CMB_H = 6'h2C;
  // Flag bit positions
  localparam int FLG_CAP = 0;
  localparam int FLG_CMA = 1;
  localparam int FLG_CMB = 2;
  // Fixed top values of the fixed-resolution PWM modes and of the full 16-bit range
  localparam logic [15:0] TOP_8BIT  = 16'h00FF;
  localparam logic [15:0] TOP_9BIT  = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] TOP_MAX   = 16'hFFFF;
  // Noise filter depth in system clocks
  localparam int FILT_LEN = 4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] CMODE_RST = 8'h00;
  // Control register layout
  typedef struct packed {
    logic       comparator_capture_select; // bit 7
    logic       capture_edge_select;       // bit 6, 1 = rising
    logic       capture_filter_enable;     // bit 5
    logic       reserved;                  // bit 4
    logic [3:0] waveform_mode_sel;         // bits 3:0
  } tcc_ctrl_t;
  // Compare mode and enable register layout
  typedef struct packed {
    logic       compare_irq_enable_b;      // bit 7
    logic       compare_irq_enable_a;      // bit 6
    logic       capture_irq_enable;        // bit 5
    logic       reserved;                  // bit 4
    logic [1:0] compare_output_mode_b;     // bits 3:2
    logic [1:0] compare_output_mode_a;     // bits 1:0
  } tcc_cmode_t;
endpackage
